// ---- logic/kbs_pkg.sv ----
// Package: shared types and constants for the burst-capture sequencer
package kbs_pkg;

  // ==========================================================================
  // Widths and constants
  localparam int unsigned ROW_W   = 16;
  localparam int unsigned TIME_W  = 32;
  localparam logic [1:0]  MODE_FREE     = 2'h0;
  localparam logic [1:0]  MODE_SINGLE   = 2'h1;
  localparam logic [1:0]  MODE_MULTIPLE = 2'h2;
  localparam logic        STAT_SHUTTER  = 1'h0;
  localparam logic        STAT_READOUT  = 1'h1;
  localparam logic [TIME_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [ROW_W-1:0]  ROW_ZERO = 16'h0000;
  localparam logic [ROW_W-1:0]  ROW_ONE  = 16'h0001;

  // ==========================================================================
  // Configuration carrier
  typedef struct packed {
    logic              burst_option;   // Option installed in the controller
    logic              burst_select;   // Software asks for burst mode
    logic [1:0]        mode;           // Timing mode
    logic              sync_falling;   // Active edge of external sync
    logic              status_select;  // 0 shutter, 1 readout indicator
    logic [TIME_W-1:0] exposure_cyc;   // Free-run and single-trigger exposure per frame
    logic [TIME_W-1:0] shift_cyc;      // Cycles per row shift
    logic [ROW_W-1:0]  frame_rows;     // Rows per frame
    logic [ROW_W-1:0]  array_rows;     // Rows of the whole array
  } kbs_cfg_t;

  // Status carrier
  typedef struct packed {
    logic             ready;
    logic             shutter_open;
    logic             shifting;
    logic             readout_active;
    logic [ROW_W-1:0] frame_index;
  } kbs_stat_t;

endpackage : kbs_pkg

// ---- logic/kbs_edge_sync.sv ----
// Sync-input synchroniser and selectable edge detector
module kbs_edge_sync (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic sync_in,
  input  wire logic falling,
  output logic      edge_pulse
);

  logic meta_q, meta_d;
  logic stab_q, stab_d;
  logic prev_q, prev_d;

  // ==========================================================================
  // Two-stage synchroniser then edge compare on the stable stage
  always_comb begin
    meta_d = sync_in;
    stab_d = meta_q;
    prev_d = stab_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= 1'b0;
      stab_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      prev_q <= prev_d;
    end
  end

  assign edge_pulse = falling ? (prev_q & ~stab_q) : (stab_q & ~prev_q);

  one_pulse_a: assert property (@(posedge clock) disable iff (srst)
    edge_pulse |=> !edge_pulse) else $error("sync edge lasted more than one cycle");

endmodule // kbs_edge_sync

// ---- logic/kbs_sequencer.sv ----
// Burst-capture (kinetics) sequencer: exposure, shift under mask, readout
//
// Overview of operation
// - Three timing modes: free run, one trigger per series, one per frame.
// - Shutter open: after each exposure, shift charge under mask, expose again.
// - After last frame, close shutter, then read out stored frames.
// - Free run needs no triggers; every frame exposed for programmed duration.
// - Gap between frames equals row shift period times frame height.
// - Frames per series equals array rows divided by frame height.
// - Status output shows shutter signal or readout-active signal.
// - Single trigger: each valid sync edge starts a complete series.
// - Single trigger: readout at normal speed; next trigger only after readout.
// - Multiple trigger: each sync edge advances one frame until series done.
// - Multiple trigger: shutter open all series; pulse spacing sets exposure.
// - Multiple trigger: after last frame close, read out, then return to ready.
// - Burst mode usable only when burst option is installed.
// - Sync active edge selectable rising or falling.
// - Readout selection: status low during readout, high otherwise.
// - Shutter selection: status high while shutter open, one cycle later; default.
module kbs_sequencer (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire kbs_pkg::kbs_cfg_t cfg,
  input  wire logic             start,
  input  wire logic             sync_in,
  input  wire logic             readout_done,
  output logic                  shutter_open,
  output logic                  shift_rows,
  output logic                  readout_start,
  output logic                  readout_active_indicator,
  output logic                  status_out,
  output logic                  burst_enabled,
  output kbs_pkg::kbs_stat_t    stat
);

  typedef enum logic [4:0] {
    KBS_IDLE   = 5'b00001,
    KBS_EXPOSE = 5'b00010,
    KBS_SHIFT  = 5'b00100,
    KBS_CLOSE  = 5'b01000,
    KBS_READ   = 5'b10000
  } kbs_state_t;

  kbs_state_t                   state_q, state_d;
  logic [kbs_pkg::TIME_W-1:0]   cnt_q, cnt_d;
  logic [kbs_pkg::ROW_W-1:0]    frame_q, frame_d;
  logic [kbs_pkg::ROW_W-1:0]    nframes_q, nframes_d;
  logic                         shut_q, shut_d;
  logic                         shift_q, shift_d;
  logic                         rdstart_q, rdstart_d;
  logic                         rdact_q, rdact_d;
  logic                         status_q, status_d;
  logic                         sel_q, sel_d;
  logic                         trig;
  logic                         last_frame;

  // ==========================================================================
  // Helpers
  function automatic logic [kbs_pkg::TIME_W-1:0] gap_cycles(
    input logic [kbs_pkg::TIME_W-1:0] per_row,
    input logic [kbs_pkg::ROW_W-1:0]  rows);
    logic [kbs_pkg::TIME_W+kbs_pkg::ROW_W-1:0] prod;
    prod = per_row * rows;
    return prod[kbs_pkg::TIME_W-1:0];
  endfunction

  function automatic logic [kbs_pkg::ROW_W-1:0] frame_count(
    input logic [kbs_pkg::ROW_W-1:0] arr,
    input logic [kbs_pkg::ROW_W-1:0] fr);
    logic [kbs_pkg::ROW_W-1:0] q;
    q = (fr == kbs_pkg::ROW_ZERO) ? kbs_pkg::ROW_ZERO : arr / fr;
    return (q == kbs_pkg::ROW_ZERO) ? kbs_pkg::ROW_ONE : q;
  endfunction

  // ==========================================================================
  // External sync edge
  kbs_edge_sync u_edge (
    .clock      (clock),
    .srst       (srst),
    .sync_in    (sync_in),
    .falling    (cfg.sync_falling),
    .edge_pulse (trig)
  );

  assign burst_enabled = cfg.burst_option & cfg.burst_select;
  assign last_frame    = (frame_q + kbs_pkg::ROW_ONE) >= nframes_q;

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    frame_d   = frame_q;
    nframes_d = nframes_q;
    shut_d    = shut_q;
    shift_d   = 1'b0;
    rdstart_d = 1'b0;
    rdact_d   = rdact_q;
    unique case (state_q)
      KBS_IDLE: begin
        frame_d = kbs_pkg::ROW_ZERO;
        if (burst_enabled) begin
          nframes_d = frame_count(cfg.array_rows, cfg.frame_rows);
          unique case (cfg.mode)
            kbs_pkg::MODE_FREE: begin
              if (start) begin
                state_d = KBS_EXPOSE;
                shut_d  = 1'b1;
                cnt_d   = cfg.exposure_cyc;
              end
            end
            kbs_pkg::MODE_SINGLE: begin
              if (trig) begin
                state_d = KBS_EXPOSE;
                shut_d  = 1'b1;
                cnt_d   = cfg.exposure_cyc;
              end
            end
            kbs_pkg::MODE_MULTIPLE: begin
              if (start) begin
                state_d = KBS_EXPOSE;
                shut_d  = 1'b1;
                cnt_d   = kbs_pkg::CNT_ZERO;
              end
            end
            default: begin
            end
          endcase
        end
      end
      KBS_EXPOSE: begin
        // Multiple trigger: the exposure ends only on a sync edge
        if (cfg.mode == kbs_pkg::MODE_MULTIPLE) begin
          if (trig) begin
            state_d = KBS_SHIFT;
            shift_d = 1'b1;
            cnt_d   = gap_cycles(cfg.shift_cyc, cfg.frame_rows);
          end
        end else if (cnt_q <= 32'h0000_0001) begin
          state_d = KBS_SHIFT;
          shift_d = 1'b1;
          cnt_d   = gap_cycles(cfg.shift_cyc, cfg.frame_rows);
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      KBS_SHIFT: begin
        shift_d = 1'b1;
        if (cnt_q <= 32'h0000_0001) begin
          shift_d = 1'b0;
          if (last_frame) begin
            state_d = KBS_CLOSE;
            shut_d  = 1'b0;
          end else begin
            state_d = KBS_EXPOSE;
            frame_d = frame_q + kbs_pkg::ROW_ONE;
            cnt_d   = cfg.exposure_cyc;
          end
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      KBS_CLOSE: begin
        state_d   = KBS_READ;
        rdstart_d = 1'b1;
        rdact_d   = 1'b1;
      end
      KBS_READ: begin
        if (readout_done) begin
          state_d = KBS_IDLE;
          rdact_d = 1'b0;
        end
      end
      default: begin
        state_d = KBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q   <= KBS_IDLE;
      cnt_q     <= kbs_pkg::CNT_ZERO;
      frame_q   <= kbs_pkg::ROW_ZERO;
      nframes_q <= kbs_pkg::ROW_ONE;
      shut_q    <= 1'b0;
      shift_q   <= 1'b0;
      rdstart_q <= 1'b0;
      rdact_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      frame_q   <= frame_d;
      nframes_q <= nframes_d;
      shut_q    <= shut_d;
      shift_q   <= shift_d;
      rdstart_q <= rdstart_d;
      rdact_q   <= rdact_d;
    end
  end

  // ==========================================================================
  // Status output selection
  // Selection is registered so that a reset always restores the shutter view
  always_comb begin
    sel_d    = cfg.status_select;
    status_d = (sel_q == kbs_pkg::STAT_READOUT) ? ~rdact_q : shut_q;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sel_q    <= kbs_pkg::STAT_SHUTTER;
      status_q <= 1'b0;
    end else begin
      sel_q    <= sel_d;
      status_q <= status_d;
    end
  end

  assign shutter_open             = shut_q;
  assign shift_rows               = shift_q;
  assign readout_start            = rdstart_q;
  assign readout_active_indicator = ~rdact_q;
  assign status_out               = status_q;
  assign stat = '{
    ready:          (state_q == KBS_IDLE),
    shutter_open:   shut_q,
    shifting:       shift_q,
    readout_active: rdact_q,
    frame_index:    frame_q
  };

  // ==========================================================================
  // Checks
  no_burst_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_IDLE && !burst_enabled) |=> state_q == KBS_IDLE)
    else $error("sequence started without burst option");
  shut_read_a: assert property (@(posedge clock) disable iff (srst)
    rdact_q |-> !shut_q) else $error("shutter open during readout");
  close_read_a: assert property (@(posedge clock) disable iff (srst)
    state_q == KBS_CLOSE |=> rdstart_q && rdact_q) else $error("readout not started after close");
  multi_hold_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_EXPOSE && cfg.mode == kbs_pkg::MODE_MULTIPLE && !trig) |=> state_q == KBS_EXPOSE)
    else $error("multiple trigger frame advanced without edge");
  multi_shut_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_SHIFT && !last_frame) |=> shut_q) else $error("shutter closed mid series");
  read_ignore_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_READ && !readout_done) |=> state_q == KBS_READ)
    else $error("left readout before done");
  single_go_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_IDLE && burst_enabled && cfg.mode == kbs_pkg::MODE_SINGLE && trig) |=> shut_q ##0
    state_q == KBS_EXPOSE) else $error("single trigger did not start series");
  stat_shut_a: assert property (@(posedge clock) disable iff (srst)
    $past(sel_q) == kbs_pkg::STAT_SHUTTER |-> status_q == $past(shut_q))
    else $error("status does not follow shutter");
  stat_read_a: assert property (@(posedge clock) disable iff (srst)
    $past(sel_q) == kbs_pkg::STAT_READOUT |-> status_q == !$past(rdact_q))
    else $error("status does not follow readout");
  frame_lim_a: assert property (@(posedge clock) disable iff (srst)
    state_q != KBS_IDLE |-> frame_q < nframes_q) else $error("frame count beyond series");

  // ==========================================================================
  // Sequencing steps
  free_go_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_IDLE && burst_enabled && cfg.mode == kbs_pkg::MODE_FREE && start) |=>
    (shut_q && state_q == KBS_EXPOSE && cnt_q == cfg.exposure_cyc)) else $error("free run did not start");
  bad_mode_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_IDLE && cfg.mode == 2'h3) |=> state_q == KBS_IDLE)
    else $error("series started in an undefined mode");
  shift_open_a: assert property (@(posedge clock) disable iff (srst)
    shift_q |-> shut_q) else $error("rows shifted with shutter closed");
  gap_load_a: assert property (@(posedge clock) disable iff (srst)
    $rose(shift_q) |-> cnt_q == cfg.shift_cyc * cfg.frame_rows) else $error("shift gap length wrong");
  next_frame_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_SHIFT && cnt_q <= 32'h0000_0001 && !last_frame) |=>
    (state_q == KBS_EXPOSE && shut_q && frame_q == $past(frame_q) + kbs_pkg::ROW_ONE))
    else $error("next exposure did not follow shift");
  last_close_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_SHIFT && cnt_q <= 32'h0000_0001 && last_frame) |=> (state_q == KBS_CLOSE && !shut_q))
    else $error("shutter not closed after last frame");
  read_end_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_READ && readout_done) |=> (state_q == KBS_IDLE && !rdact_q))
    else $error("not ready after readout");
  busy_ignore_a: assert property (@(posedge clock) disable iff (srst)
    (state_q inside {KBS_CLOSE, KBS_READ} && trig) |=> !shut_q)
    else $error("sync edge reopened shutter during readout");
  exp_count_a: assert property (@(posedge clock) disable iff (srst)
    (state_q == KBS_EXPOSE && cfg.mode != kbs_pkg::MODE_MULTIPLE && cnt_q > 32'h0000_0001) |=>
    state_q == KBS_EXPOSE)
    else $error("exposure ended early");
  rd_pulse_a: assert property (@(posedge clock) disable iff (srst)
    rdstart_q |=> !rdstart_q) else $error("readout start lasted more than one cycle");
  ind_level_a: assert property (@(posedge clock) disable iff (srst)
    readout_active_indicator == !(state_q == KBS_READ)) else $error("indicator wrong outside readout");
  idle_quiet_a: assert property (@(posedge clock) disable iff (srst)
    state_q == KBS_IDLE |-> (!shut_q && !shift_q && !rdact_q)) else $error("idle with shutter or readout active");

endmodule // kbs_sequencer

// ---- test/kbs_readout_model.sv ----
// Readout engine model: ends each readout a fixed number of cycles after it starts
module kbs_readout_model #(
  parameter int DELAY = 40
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic readout_start,
  output logic      readout_done
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_q;

  // ==========================================================================
  // Normal-speed readout of the stored frames
  always_ff @(posedge clock) begin
    readout_done <= 1'b0;
    if (srst) begin
      cnt_q <= 0;
    end else if (readout_start) begin
      cnt_q <= DELAY;
    end else if (cnt_q > 0) begin
      cnt_q        <= cnt_q - 1;
      readout_done <= (cnt_q == 1);
    end
  end
endmodule // kbs_readout_model

// ---- test/test_kinetics_burst_sequencer.sv ----
// Testbench for the burst-capture sequencer
module test_kinetics_burst_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock    = 1'b0;
  logic              srst     = 1'b1;
  kbs_pkg::kbs_cfg_t cfg      = '0;
  logic              start    = 1'b0;
  logic              sync_in  = 1'b0;
  logic              readout_done;
  logic              shutter_open;
  logic              shift_rows;
  logic              readout_start;
  logic              ind;
  logic              status_out;
  logic              burst_enabled;
  kbs_pkg::kbs_stat_t stat;
  logic [31:0]       error_cnt = 0;
  logic [31:0]       n_checks  = 0;
  // Counters: opens, closes, shifts, shift cycles, expose cycles, readouts
  logic [31:0]       cnt [6]   = '{default: 0};
  logic [31:0]       base [6];
  logic              ro_q      = 1'b0;
  logic              prev_sh   = 1'b0;
  logic              prev_sft  = 1'b0;
  logic              prev_st   = 1'b0;
  logic              prev_sel  = 1'b0;
  logic              prev_rst  = 1'b1;

  kbs_sequencer u_dut (.clock(clock), .srst(srst), .cfg(cfg), .start(start), .sync_in(sync_in),
    .readout_done(readout_done), .shutter_open(shutter_open), .shift_rows(shift_rows),
    .readout_start(readout_start), .readout_active_indicator(ind), .status_out(status_out),
    .burst_enabled(burst_enabled), .stat(stat));

  kbs_readout_model u_model (.clock(clock), .srst(srst), .readout_start(readout_start),
    .readout_done(readout_done));

  initial forever #4 clock = ~clock;

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic setup(input logic [1:0] m, input logic f, s, input logic [31:0] ex, sh,
                       input logic [15:0] fr, ar);
    cfg     <= '{1'b1, 1'b1, m, f, s, ex, sh, fr, ar};
    sync_in <= f;
    repeat (5) @(posedge clock);
    base = cnt;
  endtask

  task automatic pulse_start();
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
  endtask

  task automatic pulse_sync(input int gap);
    sync_in <= ~cfg.sync_falling;
    repeat (4) @(posedge clock);
    sync_in <= cfg.sync_falling;
    repeat (gap) @(posedge clock);
  endtask

  task automatic wait_ready(input logic [31:0] e [6], input string name);
    int i;
    for (i = 0; i < 5000 && !(cnt[5] != base[5] && stat.ready === 1'b1); i++) @(posedge clock);
    if (i == 5000) begin
      check(0, 1);
      give_verdict();
    end
    repeat (2) @(posedge clock);
    for (i = 0; i < 6; i++) if (e[i] !== 32'hFFFF_FFFF) check(cnt[i] - base[i], e[i]);
    $display("Test %s done", name);
  endtask

  // ==========================================================================
  // Port monitor
  always @(posedge clock) begin
    if (!srst && !prev_rst) begin
      check(status_out, prev_st);
      check(ind, 1'(~(readout_start | ro_q)));
      if (readout_start) check(shutter_open, 1'b0);
      check(stat.shutter_open, shutter_open);
      check(stat.shifting, shift_rows);
      check(stat.readout_active, 1'(~ind));
      if (shutter_open) check(stat.ready, 0);
      if (shift_rows & ~prev_sft) check(stat.frame_index, cnt[2] - base[2]);
    end
    cnt[0]   <= cnt[0] + (shutter_open & ~prev_sh);
    cnt[1]   <= cnt[1] + (~shutter_open & prev_sh);
    cnt[2]   <= cnt[2] + (shift_rows & ~prev_sft);
    cnt[3]   <= cnt[3] + shift_rows;
    cnt[4]   <= cnt[4] + (shutter_open & ~shift_rows);
    cnt[5]   <= cnt[5] + readout_start;
    ro_q     <= !srst && (readout_start || (ro_q && !readout_done));
    prev_sh  <= shutter_open;
    prev_sft <= shift_rows;
    prev_st  <= prev_sel ? ind : shutter_open;
    prev_sel <= cfg.status_select;
    prev_rst <= srst;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    check(shutter_open, 0);
    check(status_out, 0);
    check(stat.ready, 1);
    cfg <= '{1'b0, 1'b1, kbs_pkg::MODE_FREE, 1'b0, 1'b0, 32'h0000_0002, 32'h0000_0001, 16'h0001, 16'h0002};
    repeat (2) @(posedge clock);
    base = cnt;
    check(burst_enabled, 0);
    pulse_start();
    repeat (20) @(posedge clock);
    check(cnt[0] - base[0], 0);
    $display("Test burst_off done");
    setup(2'h3, 1'b0, 1'b0, 2, 1, 1, 2);
    pulse_start();
    pulse_sync(2);
    repeat (10) @(posedge clock);
    check(cnt[0] - base[0], 0);
    $display("Test bad_mode done");
    setup(kbs_pkg::MODE_FREE, 1'b0, 1'b0, 3, 2, 2, 6);
    check(burst_enabled, 1);
    pulse_start();
    wait_ready('{1, 1, 3, 12, 9, 1}, "free");
    setup(kbs_pkg::MODE_FREE, 1'b0, 1'b1, 1, 1, 2, 5);
    pulse_start();
    wait_ready('{1, 1, 2, 4, 2, 1}, "free_readout_sel");
    setup(kbs_pkg::MODE_FREE, 1'b0, 1'b0, 2, 1, 0, 4);
    pulse_start();
    wait_ready('{1, 1, 1, 1, 2, 1}, "free_zero_rows");
    setup(kbs_pkg::MODE_SINGLE, 1'b0, 1'b0, 2, 1, 1, 3);
    pulse_sync(2);
    check(shutter_open, 1);
    for (i = 0; i < 5000 && cnt[5] == base[5]; i++) @(posedge clock);
    if (i == 5000) begin
      check(0, 1);
      give_verdict();
    end
    pulse_sync(2);
    wait_ready('{1, 1, 3, 3, 6, 1}, "single_rise");
    repeat (30) @(posedge clock);
    check(cnt[0] - base[0], 1);
    setup(kbs_pkg::MODE_SINGLE, 1'b1, 1'b0, 2, 1, 1, 3);
    pulse_sync(2);
    check(shutter_open, 1);
    wait_ready('{1, 1, 3, 3, 6, 1}, "single_fall");
    setup(kbs_pkg::MODE_MULTIPLE, 1'b0, 1'b0, 0, 1, 2, 6);
    pulse_start();
    pulse_sync(10);
    pulse_sync(20);
    pulse_sync(5);
    pulse_sync(5);
    wait_ready('{1, 1, 3, 6, 38, 1}, "multiple");
    give_verdict();
  end
endmodule // test_kinetics_burst_sequencer
